// ==== rtl/mcf_regs.svh ====
// register map, field positions, reset values and cycle counts of the flow core
// Notes on behaviour
// - decrement, test, clear: one cycle, Z N V only; set-all-ones: no flags.
// - plain multiplies take two cycles, product to pair, Z and C only.
// - fractional multiplies take two cycles, product shifted left once.
// - relative jump PC+k+1 in two, pointer jump two, absolute three.
// - relative and pointer calls four, direct five; returns five.
// - compare-skip-equal skips when equal; one cycle, two or three skipping.
// - compares set Z N V C H in one cycle, result not stored.
// - register bit skips test the chosen bit clear or set.
// - I/O bit skips test the chosen bit clear or set.
// - status bit branches add k+1 when bit matches; one or two cycles.
// - equal/not-equal on Z, carry and lower/higher on C, minus/plus on N.
// - signed ge taken on N xor V zero, less-than on one.
// - half carry branches test H, same target and timing.
// - transfer branches test T, one or two cycles, no flags.
// - overflow branch taken when V is one, one or two cycles.
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH
`define MCF_IDX_CMD 3'h0
`define MCF_IDX_OPND 3'h1
`define MCF_IDX_TGT 3'h2
`define MCF_IDX_PC 3'h3
`define MCF_IDX_STATUS_FLAGS_REGISTER 3'h4
`define MCF_IDX_RES 3'h5
`define MCF_IDX_PROD 3'h6
`define MCF_IDX_LSB 2
`define MCF_IDX_MSB 4
`define MCF_FLD_RR 8
`define MCF_FLD_BIT 16
`define MCF_FLD_TWO 19
`define MCF_FLD_KMSB 11
`define MCF_FLD_TGT 16
`define MCF_F_C 0
`define MCF_F_Z 1
`define MCF_F_N 2
`define MCF_F_V 3
`define MCF_F_S 4
`define MCF_F_H 5
`define MCF_F_T 6
`define MCF_F_I 7
`define MCF_RST_PC 16'h0000
`define MCF_RST_STATUS_FLAGS_REGISTER 8'h00
`define MCF_PC_STEP 16'h0001
`define MCF_PC_SKIP1 16'h0002
`define MCF_PC_SKIP2 16'h0003
`define MCF_CYC_ALU 3'h1
`define MCF_CYC_MUL 3'h2
`define MCF_CYC_JREL 3'h2
`define MCF_CYC_JABS 3'h3
`define MCF_CYC_CREL 3'h4
`define MCF_CYC_CABS 3'h5
`define MCF_CYC_RET 3'h5
`define MCF_CYC_TAKEN 3'h2
`define MCF_CYC_SKIP1 3'h2
`define MCF_CYC_SKIP2 3'h3
`define MCF_RESP_OKAY 2'h0
`define MCF_RESP_SLVERR 2'h2
`endif

// ==== rtl/mcf_pkg.sv ====
// operation codes and state types of the flow core
package mcf_pkg;
  typedef enum logic [5:0] {
    decrement_op = 6'h00, self_and_test_op = 6'h01, self_xor_clear_op = 6'h02,
    set_all_ones_op = 6'h03, unsigned_multiply_op = 6'h04, signed_multiply_op = 6'h05,
    mixed_sign_multiply_op = 6'h06, fractional_unsigned_multiply_op = 6'h07,
    fractional_signed_multiply_op = 6'h08, fractional_mixed_multiply_op = 6'h09,
    relative_jump_op = 6'h0A, pointer_jump_op = 6'h0B, absolute_jump_op = 6'h0C,
    relative_call_op = 6'h0D, pointer_call_op = 6'h0E, direct_call_op = 6'h0F,
    subroutine_return_op = 6'h10, interrupt_return_op = 6'h11, compare_skip_equal_op = 6'h12,
    compare_op = 6'h13, compare_with_carry_op = 6'h14, compare_immediate_op = 6'h15,
    skip_reg_bit_clear_op = 6'h16, skip_reg_bit_set_op = 6'h17, skip_io_bit_clear_op = 6'h18,
    skip_io_bit_set_op = 6'h19, branch_status_bit_set_op = 6'h1A,
    branch_status_bit_clear_op = 6'h1B, branch_equal_op = 6'h1C, branch_not_equal_op = 6'h1D,
    branch_carry_set_op = 6'h1E, branch_carry_clear_op = 6'h1F, branch_same_higher_op = 6'h20,
    branch_lower_op = 6'h21, branch_minus_op = 6'h22, branch_plus_op = 6'h23,
    branch_signed_ge_op = 6'h24, branch_signed_lt_op = 6'h25, branch_half_carry_set_op = 6'h26,
    branch_half_carry_clear_op = 6'h27, branch_transfer_set_op = 6'h28,
    branch_transfer_clear_op = 6'h29, branch_overflow_set_op = 6'h2A
  } mcf_op_type;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EXEC = 1'b1} mcf_state_type;
endpackage

// ==== rtl/mcf_core.sv ====
// flow, compare and multiply execution core behind an AXI4-Lite register port
`timescale 1ns/10ps
`include "mcf_regs.svh"
module mcf_core #(
  parameter int ADDR_W = 8 // register address width, at least 6
) (
  input wire logic I_REF_CLK, // core clock
  input wire logic I_RST, // async reset, high
  input wire logic I_AXI_AWVALID, // write address valid
  output logic O_AXI_AWREADY, // write address ready
  input wire logic [ADDR_W-1:0] I_AXI_AWADDR, // write address
  input wire logic I_AXI_WVALID, // write data valid
  output logic O_AXI_WREADY, // write data ready
  input wire logic [31:0] I_AXI_WDATA, // write data
  input wire logic [3:0] I_AXI_WSTRB, // byte strobes
  output logic O_AXI_BVALID, // write response valid
  input wire logic I_AXI_BREADY, // write response ready
  output logic [1:0] O_AXI_BRESP, // write response
  input wire logic I_AXI_ARVALID, // read address valid
  output logic O_AXI_ARREADY, // read address ready
  input wire logic [ADDR_W-1:0] I_AXI_ARADDR, // read address
  output logic O_AXI_RVALID, // read data valid
  input wire logic I_AXI_RREADY, // read data ready
  output logic [31:0] O_AXI_RDATA, // read data
  output logic [1:0] O_AXI_RRESP, // read response
  output logic O_BUSY // operation in progress
);
  import mcf_pkg::*;

  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [ADDR_W-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rdat_q, rdat_d, wm;
  logic [3:0] ws_q, ws_d, wsel, rsel;
  logic [1:0] br_q, br_d, rrs_q, rrs_d;
  logic wr_go, wr_ok, start, cond, frac;
  logic tk_q, tk_d; // taken or skipped flag of the last operation
  mcf_state_type st_q, st_d;
  mcf_op_type op_q, op_d, op_in;
  logic [2:0] cnt_q, cnt_d;
  logic [19:0] opnd_q, opnd_d;
  logic [31:0] tgt_q, tgt_d;
  logic [15:0] pc_q, pc_d, prod_q, prod_d, ret_q, ret_d, rel, skp, tgt, mprod;
  logic [7:0] status_flags_register_q, status_flags_register_d, res_q, res_d, rd, rr, dif;
  logic [2:0] bsel;
  logic signed [8:0] ma, mb;
  logic signed [17:0] mfull;

  // register index with a hit flag in the top bit
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    decode = {1'b0, a[`MCF_IDX_MSB:`MCF_IDX_LSB]};
    if (a[ADDR_W-1:`MCF_IDX_MSB+1] == '0 && a[`MCF_IDX_LSB-1:0] == '0 && decode[2:0] <= `MCF_IDX_PROD) begin
      decode[3] = 1'b1;
    end
  endfunction

  // byte lane merge under the write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // zero, negative and overflow flags of a logic result; sign is left alone so only listed flags move
  function automatic logic [7:0] lflags(input logic [7:0] s, input logic [7:0] r, input logic v);
    lflags = s;
    lflags[`MCF_F_Z] = (r == 8'h00);
    lflags[`MCF_F_N] = r[7];
    lflags[`MCF_F_V] = v;
  endfunction

  assign wsel = decode(awa_q);
  assign rsel = decode(I_AXI_ARADDR);
  assign O_AXI_AWREADY = !aw_q;
  assign O_AXI_WREADY = !w_q;
  assign O_AXI_BVALID = bv_q;
  assign O_AXI_BRESP = br_q;
  assign O_AXI_ARREADY = !rv_q;
  assign O_AXI_RVALID = rv_q;
  assign O_AXI_RDATA = rdat_q;
  assign O_AXI_RRESP = rrs_q;
  assign O_BUSY = (st_q == ST_EXEC);

  // bus handshakes: address and data are caught apart, the response follows both
  always_comb begin
    aw_d = aw_q;
    awa_d = awa_q;
    w_d = w_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rdat_d = rdat_q;
    rrs_d = rrs_q;
    // result and product are read only; a command during a busy period is refused
    wr_ok = wsel[3] && wsel[2:0] < `MCF_IDX_RES && !(wsel[2:0] == `MCF_IDX_CMD && O_BUSY);
    wr_go = aw_q && w_q && !bv_q;
    if (I_AXI_AWVALID && !aw_q) begin
      aw_d = 1'b1;
      awa_d = I_AXI_AWADDR;
    end
    if (I_AXI_WVALID && !w_q) begin
      w_d = 1'b1;
      wd_d = I_AXI_WDATA;
      ws_d = I_AXI_WSTRB;
    end
    if (bv_q && I_AXI_BREADY) begin
      bv_d = 1'b0;
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = wr_ok ? `MCF_RESP_OKAY : `MCF_RESP_SLVERR;
    end
    if (rv_q && I_AXI_RREADY) begin
      rv_d = 1'b0;
    end
    if (I_AXI_ARVALID && !rv_q) begin
      rv_d = 1'b1;
      rrs_d = rsel[3] ? `MCF_RESP_OKAY : `MCF_RESP_SLVERR;
      case (rsel[2:0])
        `MCF_IDX_CMD: rdat_d = {26'h000_0000, op_q};
        `MCF_IDX_OPND: rdat_d = {12'h000, opnd_q};
        `MCF_IDX_TGT: rdat_d = tgt_q;
        `MCF_IDX_PC: rdat_d = {16'h0000, pc_q};
        `MCF_IDX_STATUS_FLAGS_REGISTER: rdat_d = {24'h00_0000, status_flags_register_q};
        `MCF_IDX_RES: rdat_d = {ret_q, 6'h00, tk_q, O_BUSY, res_q};
        `MCF_IDX_PROD: rdat_d = {16'h0000, prod_q};
        default: rdat_d = 32'h0000_0000;
      endcase
      if (!rsel[3]) begin
        rdat_d = 32'h0000_0000;
      end
    end
  end

  // bus handshake registers
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      aw_q <= 1'b0;
      awa_q <= '0;
      w_q <= 1'b0;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= `MCF_RESP_OKAY;
      rv_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      rrs_q <= `MCF_RESP_OKAY;
    end else begin
      aw_q <= aw_d;
      awa_q <= awa_d;
      w_q <= w_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
      rrs_q <= rrs_d;
    end
  end

  // operand fields and shared datapath terms
  assign start = wr_go && wr_ok && wsel[2:0] == `MCF_IDX_CMD && ws_q[0];
  assign op_in = mcf_op_type'(wd_q[5:0]);
  assign rd = opnd_q[7:0];
  assign rr = opnd_q[`MCF_FLD_RR +: 8];
  assign bsel = opnd_q[`MCF_FLD_BIT +: 3];
  assign tgt = tgt_q[`MCF_FLD_TGT +: 16];
  assign rel = pc_q + {{4{tgt_q[`MCF_FLD_KMSB]}}, tgt_q[`MCF_FLD_KMSB:0]} + `MCF_PC_STEP;
  assign skp = pc_q + (opnd_q[`MCF_FLD_TWO] ? `MCF_PC_SKIP2 : `MCF_PC_SKIP1);
  assign dif = rd - rr - {7'h00, op_in == compare_with_carry_op && status_flags_register_q[`MCF_F_C]};

  // one 9x9 signed multiplier serves all six variants by sign-extending per operand
  assign ma = {op_in inside {signed_multiply_op, mixed_sign_multiply_op, fractional_signed_multiply_op,
    fractional_mixed_multiply_op} && rd[7], rd};
  assign mb = {op_in inside {signed_multiply_op, fractional_signed_multiply_op} && rr[7], rr};
  assign mfull = ma * mb;
  assign frac = op_in inside {fractional_unsigned_multiply_op, fractional_signed_multiply_op,
    fractional_mixed_multiply_op};
  assign mprod = frac ? {mfull[14:0], 1'b0} : mfull[15:0];

  // skip and branch conditions; the I/O bit is sampled by software into the source field
  always_comb begin
    case (op_in)
      compare_skip_equal_op: cond = (rd == rr);
      skip_reg_bit_clear_op, skip_io_bit_clear_op: cond = !rr[bsel];
      skip_reg_bit_set_op, skip_io_bit_set_op: cond = rr[bsel];
      branch_status_bit_set_op: cond = status_flags_register_q[bsel];
      branch_status_bit_clear_op: cond = !status_flags_register_q[bsel];
      branch_equal_op: cond = status_flags_register_q[`MCF_F_Z];
      branch_not_equal_op: cond = !status_flags_register_q[`MCF_F_Z];
      branch_carry_set_op, branch_lower_op: cond = status_flags_register_q[`MCF_F_C];
      branch_carry_clear_op, branch_same_higher_op: cond = !status_flags_register_q[`MCF_F_C];
      branch_minus_op: cond = status_flags_register_q[`MCF_F_N];
      branch_plus_op: cond = !status_flags_register_q[`MCF_F_N];
      branch_signed_ge_op: cond = !(status_flags_register_q[`MCF_F_N] ^ status_flags_register_q[`MCF_F_V]);
      branch_signed_lt_op: cond = status_flags_register_q[`MCF_F_N] ^ status_flags_register_q[`MCF_F_V];
      branch_half_carry_set_op: cond = status_flags_register_q[`MCF_F_H];
      branch_half_carry_clear_op: cond = !status_flags_register_q[`MCF_F_H];
      branch_transfer_set_op: cond = status_flags_register_q[`MCF_F_T];
      branch_transfer_clear_op: cond = !status_flags_register_q[`MCF_F_T];
      branch_overflow_set_op: cond = status_flags_register_q[`MCF_F_V];
      default: cond = 1'b0;
    endcase
  end

  // register writes and execution; results commit at the start edge, busy covers the cycle count
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q;
    opnd_d = opnd_q;
    tgt_d = tgt_q;
    pc_d = pc_q;
    status_flags_register_d = status_flags_register_q;
    res_d = res_q;
    prod_d = prod_q;
    ret_d = ret_q;
    tk_d = tk_q;
    wm = 32'h0000_0000;
    if (wr_go && wr_ok) begin
      case (wsel[2:0])
        `MCF_IDX_OPND: begin
          wm = merge({12'h000, opnd_q}, wd_q, ws_q);
          opnd_d = wm[19:0];
        end
        `MCF_IDX_TGT: tgt_d = merge(tgt_q, wd_q, ws_q);
        `MCF_IDX_PC: begin
          wm = merge({16'h0000, pc_q}, wd_q, ws_q);
          pc_d = wm[15:0];
        end
        `MCF_IDX_STATUS_FLAGS_REGISTER: begin
          wm = merge({24'h00_0000, status_flags_register_q}, wd_q, ws_q);
          status_flags_register_d = wm[7:0];
        end
        default: ;
      endcase
    end
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_EXEC;
          op_d = op_in;
          pc_d = pc_q + `MCF_PC_STEP;
          tk_d = 1'b0;
          cnt_d = `MCF_CYC_ALU;
          // flow and skip cases touch no arithmetic flag
          case (op_in)
            decrement_op: begin
              res_d = rd - 8'h01;
              status_flags_register_d = lflags(status_flags_register_q, rd - 8'h01, rd == 8'h80);
            end
            self_and_test_op: status_flags_register_d = lflags(status_flags_register_q, rd, 1'b0);
            self_xor_clear_op: begin
              res_d = 8'h00;
              status_flags_register_d = lflags(status_flags_register_q, 8'h00, 1'b0);
            end
            set_all_ones_op: res_d = 8'hFF;
            unsigned_multiply_op, signed_multiply_op, mixed_sign_multiply_op,
            fractional_unsigned_multiply_op, fractional_signed_multiply_op, fractional_mixed_multiply_op: begin
              cnt_d = `MCF_CYC_MUL;
              prod_d = mprod;
              status_flags_register_d[`MCF_F_C] = mfull[15];
              status_flags_register_d[`MCF_F_Z] = (mprod == 16'h0000);
            end
            relative_jump_op: begin
              pc_d = rel;
              cnt_d = `MCF_CYC_JREL;
            end
            pointer_jump_op, absolute_jump_op: begin
              pc_d = tgt;
              cnt_d = (op_in == pointer_jump_op) ? `MCF_CYC_JREL : `MCF_CYC_JABS;
            end
            relative_call_op, pointer_call_op, direct_call_op: begin
              // return address skips the second word of a direct call
              ret_d = pc_q + ((op_in == direct_call_op) ? `MCF_PC_SKIP1 : `MCF_PC_STEP);
              pc_d = (op_in == relative_call_op) ? rel : tgt;
              cnt_d = (op_in == direct_call_op) ? `MCF_CYC_CABS : `MCF_CYC_CREL;
            end
            subroutine_return_op, interrupt_return_op: begin
              pc_d = tgt;
              cnt_d = `MCF_CYC_RET;
              if (op_in == interrupt_return_op) begin
                status_flags_register_d[`MCF_F_I] = 1'b1;
              end
            end
            compare_op, compare_with_carry_op, compare_immediate_op: begin
              status_flags_register_d = lflags(status_flags_register_q, dif, (rd[7] & !rr[7] & !dif[7]) | (!rd[7] & rr[7] & dif[7]));
              status_flags_register_d[`MCF_F_C] = (!rd[7] & rr[7]) | (rr[7] & dif[7]) | (dif[7] & !rd[7]);
              status_flags_register_d[`MCF_F_H] = (!rd[3] & rr[3]) | (rr[3] & dif[3]) | (dif[3] & !rd[3]);
              if (op_in == compare_with_carry_op) begin
                status_flags_register_d[`MCF_F_Z] = (dif == 8'h00) && status_flags_register_q[`MCF_F_Z];
              end
            end
            compare_skip_equal_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
            skip_io_bit_clear_op, skip_io_bit_set_op: begin
              if (cond) begin
                pc_d = skp;
                tk_d = 1'b1;
                cnt_d = opnd_q[`MCF_FLD_TWO] ? `MCF_CYC_SKIP2 : `MCF_CYC_SKIP1;
              end
            end
            default: begin
              // branches are the top codes; unused codes never satisfy the condition
              if (op_in >= branch_status_bit_set_op && cond) begin
                pc_d = rel;
                tk_d = 1'b1;
                cnt_d = `MCF_CYC_TAKEN;
              end
            end
          endcase
        end
      end
      ST_EXEC: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == `MCF_CYC_ALU) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q <= ST_IDLE;
      op_q <= decrement_op;
      cnt_q <= 3'h0;
      opnd_q <= 20'h0_0000;
      tgt_q <= 32'h0000_0000;
      pc_q <= `MCF_RST_PC;
      status_flags_register_q <= `MCF_RST_STATUS_FLAGS_REGISTER;
      res_q <= 8'h00;
      prod_q <= 16'h0000;
      ret_q <= 16'h0000;
      tk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      opnd_q <= opnd_d;
      tgt_q <= tgt_d;
      pc_q <= pc_d;
      status_flags_register_q <= status_flags_register_d;
      res_q <= res_d;
      prod_q <= prod_d;
      ret_q <= ret_d;
      tk_q <= tk_d;
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  a_dec_value: assert property (start && op_in == decrement_op |=>
    res_q == $past(rd) - 8'h01 && status_flags_register_q[`MCF_F_C] == $past(status_flags_register_q[`MCF_F_C]))
    else $error("decrement result or carry wrong");
  a_ser_flags: assert property (start && op_in == set_all_ones_op |=>
    res_q == 8'hFF && status_flags_register_q == $past(status_flags_register_q))
    else $error("set all ones wrong");
  a_mul_product: assert property (start && op_in == unsigned_multiply_op |=>
    prod_q == 16'($past(rd) * $past(rr)) ##1 O_BUSY ##1 !O_BUSY)
    else $error("unsigned product or timing wrong");
  a_fractional_signed_multiply_op_shift: assert property (start && op_in == fractional_signed_multiply_op |=>
    prod_q == 16'(($signed($past(rd)) * $signed($past(rr))) <<< 1))
    else $error("fractional signed product wrong");
  a_jabs_busy: assert property (start && op_in == absolute_jump_op |=>
    O_BUSY[*3] ##1 !O_BUSY)
    else $error("absolute jump timing wrong");
  a_relative_call_op_busy: assert property (start && op_in == relative_call_op |=>
    pc_q == $past(rel) ##0 O_BUSY[*4] ##1 !O_BUSY)
    else $error("relative call wrong");
  a_skip_long: assert property (start && op_in == compare_skip_equal_op && rd == rr && opnd_q[`MCF_FLD_TWO] |=>
    pc_q == $past(pc_q) + `MCF_PC_SKIP2 ##0 O_BUSY[*3] ##1 !O_BUSY)
    else $error("long skip wrong");
  a_cmp_nostore: assert property (start && op_in == compare_op |=>
    res_q == $past(res_q) && status_flags_register_q[`MCF_F_Z] == ($past(rd) == $past(rr)))
    else $error("compare wrong");
  a_branch_signed_ge_op_take: assert property (start && op_in == branch_signed_ge_op && !(status_flags_register_q[`MCF_F_N] ^ status_flags_register_q[`MCF_F_V]) |=>
    pc_q == $past(rel))
    else $error("signed ge branch not taken");
  a_interrupt_return_op_enable: assert property (start && op_in == interrupt_return_op |=> status_flags_register_q[`MCF_F_I])
    else $error("interrupt return left enable clear");
  a_flow_flags: assert property (start && op_in >= branch_status_bit_set_op |=> status_flags_register_q == $past(status_flags_register_q))
    else $error("branch changed flags");
endmodule

// ==== rtl/mcf_core_fix_note.sv ====
// intentionally empty
`timescale 1ns/10ps

// ==== verification/mcu_core_mul_flow_subset_tb.sv ====
// self-checking bench for the flow, compare and multiply core with a behavioural reference model
`timescale 1ns/10ps
`include "mcf_regs.svh"
module mcu_core_mul_flow_subset_tb;
  import mcf_pkg::*;
  logic clk, rst, awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry, busy, was;
  logic [7:0] aw, ar;
  logic [31:0] wd, rdat, v;
  logic [1:0] bresp, rresp, r;
  int mismatches = 0, total_checks = 0, cyc = 0, bc = 0;
  int e_pc, e_sr, e_res, e_cyc, e_prod, e_tk, e_ret, pc, sr, od, tg;

  mcf_core uut (.I_REF_CLK(clk), .I_RST(rst), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(aw),
    .I_AXI_WVALID(wv), .O_AXI_WREADY(wrdy), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hF), .O_AXI_BVALID(bv),
    .I_AXI_BREADY(bry), .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .I_AXI_ARADDR(ar),
    .O_AXI_RVALID(rv), .I_AXI_RREADY(rry), .O_AXI_RDATA(rdat), .O_AXI_RRESP(rresp), .O_BUSY(busy));

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // length of the latest busy run, counted in sampled edges
  always @(posedge clk) begin
    if (busy === 1'b1) bc <= was ? bc + 1 : 1;
    was <= (busy === 1'b1);
  end

  // hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  task end_of_test();
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // each channel holds until the rising edge that takes it; the answer is taken at the edge it is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    aw <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
    end while (bv !== 1'b1);
    rs = bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    ar <= a;
    arv <= 1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
    end while (rv !== 1'b1);
    d = rdat;
    rs = rresp;
  endtask

  function automatic int fl(int s, int m, int z, int n, int vv, int c, int h);
    return (s & ~m) | (m & (c | z << 1 | n << 2 | vv << 3 | (n ^ vv) << 4 | h << 5));
  endfunction

  // reference model: expected pc, flags, result, product and busy length of one operation
  task automatic model(input int op, input int p0, input int s, input int o, input int g);
    int rd, rs, bs, tw, k, t, x, d, a, b, p, vv, sk, fb, pol;
    int bb[15] = '{1, 1, 0, 0, 0, 0, 2, 2, 9, 9, 5, 5, 6, 6, 3};
    int bp[15] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1};
    int jc[8] = '{2, 2, 3, 4, 4, 5, 5, 5};
    rd = o & 8'hFF;
    rs = o >> 8 & 8'hFF;
    bs = o >> 16 & 3'h7;
    tw = o >> 19 & 1;
    k = g & 12'hFFF;
    if (k > 2047) k -= 4096;
    t = g >> 16 & 16'hFFFF;
    e_pc = p0 + 1;
    e_sr = s;
    e_cyc = 1;
    e_res = -1;
    sk = 0;
    e_tk = 0;
    if (op < 3) begin
      x = op == 0 ? (rd + 255) & 8'hFF : op == 1 ? rd : 0;
      vv = op == 0 && rd == 128;
      e_sr = fl(s, 8'h0E, x == 0, x >> 7, vv, 0, 0);
      if (op != 1) e_res = x;
    end
    if (op == 3) e_res = 8'hFF;
    if (op inside {[4:9]}) begin
      a = rd - (op inside {5, 6, 8, 9} && rd > 127 ? 256 : 0);
      b = rs - (op inside {5, 8} && rs > 127 ? 256 : 0);
      p = a * b & 16'hFFFF;
      e_prod = op > 6 ? p << 1 & 16'hFFFF : p;
      e_sr = fl(s, 8'h03, e_prod == 0, 0, 0, p >> 15, 0);
      e_cyc = 2;
    end
    if (op inside {[10:17]}) begin
      e_pc = op inside {10, 13} ? p0 + k + 1 : t;
      e_cyc = jc[op-10];
      if (op == 17) e_sr = s | 8'h80;
      if (op inside {[13:15]}) e_ret = (p0 + (op == 15 ? 2 : 1)) & 16'hFFFF;
    end
    if (op inside {[19:21]}) begin
      a = op == 20 ? s & 1 : 0;
      d = rd - rs - a;
      x = d & 8'hFF;
      vv = ((rd ^ rs) & (rd ^ x)) >> 7 & 1;
      e_sr = fl(s, 8'h2F, x == 0 && (op != 20 || s >> 1 & 1), x >> 7, vv, d < 0, (rd & 15) < (rs & 15) + a);
    end
    if (op == 18) sk = rd == rs;
    if (op inside {[22:25]}) sk = (rs >> bs & 1) == op[0];
    if (sk == 1) begin
      e_pc = p0 + 2 + tw;
      e_cyc = 2 + tw;
      e_tk = 1;
    end
    if (op inside {[26:42]}) begin
      fb = op < 28 ? s >> bs & 1 : bb[op-28] == 9 ? (s >> 2 ^ s >> 3) & 1 : s >> bb[op-28] & 1;
      pol = op < 28 ? op == 26 : bp[op-28];
      if (fb == pol) begin
        e_pc = p0 + k + 1;
        e_cyc = 2;
        e_tk = 1;
      end
    end
    e_pc &= 16'hFFFF;
  endtask

  initial begin
    rst = 1;
    awv = 0;
    wv = 0;
    arv = 0;
    bry = 1;
    rry = 1;
    aw = 0;
    ar = 0;
    wd = 0;
    e_prod = 0;
    void'($urandom(55402));
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    axi_rd(8'h0C, v, r);
    chk("pc reset", v, 0);
    axi_rd(8'h10, v, r);
    chk("status_flags_register reset", v, 0);
    // every op code four times; odd passes force equal operands, the last one two-word skips too
    for (int it = 0; it < 4; it++) begin
      for (int op = 0; op < 44; op++) begin
        pc = $urandom & 16'hFFFF;
        sr = $urandom & 8'hFF;
        od = $urandom;
        tg = $urandom;
        if (it[0]) od = od & ~32'h0000_FF00 | (od & 8'hFF) << 8 | (it & 2) << 18;
        axi_wr(8'h0C, pc, r);
        axi_wr(8'h10, sr, r);
        axi_wr(8'h04, od, r);
        axi_wr(8'h08, tg, r);
        model(op, pc, sr, od, tg);
        axi_wr(8'h00, op, r);
        chk("cmd resp", r, `MCF_RESP_OKAY);
        repeat (7) @(posedge clk);
        chk("busy cycles", bc, e_cyc);
        axi_rd(8'h0C, v, r);
        chk("pc", v, e_pc);
        axi_rd(8'h10, v, r);
        chk("status_flags_register", v, e_sr);
        axi_rd(8'h18, v, r);
        chk("prod", v, e_prod);
        axi_rd(8'h14, v, r);
        chk("taken", v[9], e_tk);
        chk("busy bit", v[8], 0);
        chk("return addr", v[31:16], e_ret);
        if (e_res >= 0) chk("res", 32'(v[7:0]), e_res);
      end
    end
    // refused accesses: unmapped read, read-only write, command while busy
    axi_rd(8'h1C, v, r);
    chk("unmapped resp", r, `MCF_RESP_SLVERR);
    chk("unmapped data", v, 0);
    axi_wr(8'h14, 1, r);
    chk("res write resp", r, `MCF_RESP_SLVERR);
    axi_wr(8'h08, 32'h1234_0000, r);
    axi_wr(8'h00, direct_call_op, r);
    axi_wr(8'h00, decrement_op, r);
    chk("busy cmd resp", r, `MCF_RESP_SLVERR);
    repeat (7) @(posedge clk);
    axi_rd(8'h0C, v, r);
    chk("pc after refused cmd", v, 32'h0000_1234);
    end_of_test();
  end
endmodule
